// >>> hw/pcc_cfg.svh
`ifndef PCC_CFG_SVH
`define PCC_CFG_SVH

// ---------------------------------------------------------------
// apb register map
// ---------------------------------------------------------------
`define PCC_CTRL_OFS        12'h000
`define PCC_STATUS_OFS      12'h004
`define PCC_CTRL_PSRC_BIT   0
`define PCC_ST_LOCK_BIT     0
`define PCC_ST_PSRC_BIT     1
`define PCC_ST_PD_BIT       2
`define PCC_ST_RST_BIT      3
`define PCC_ST_FB_LSB       8
`define PCC_CTRL_RST        1'b0

// ---------------------------------------------------------------
// loop setting array on the configuration bus
// ---------------------------------------------------------------
`define PCC_NUM_OUT         4
`define PCC_NUM_SET         32
`define PCC_DIV_BASE        5'h00
`define PCC_PH_BASE         5'h04
`define PCC_FB_ADDR         5'h08
`define PCC_SET_RST         8'h00
`define PCC_DIV_RST         8'h02
`define PCC_FB_RST          8'h04
`define PCC_DIV_MIN         8'h02

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PCC_CLK_PERIOD_NS   10
`define PCC_LOCK_TIME_NS    1000
`define PCC_LOCK_CYCLES     ((`PCC_LOCK_TIME_NS + `PCC_CLK_PERIOD_NS - 1) / `PCC_CLK_PERIOD_NS)
`define PCC_LOCK_CNT_W      12

// ---------------------------------------------------------------
// synchronised pin vector layout
// ---------------------------------------------------------------
`define PCC_SYNC_W          58
`define PCC_SI_LRST         0
`define PCC_SI_FRST         1
`define PCC_SI_BRST         2
`define PCC_SI_CRST         3
`define PCC_SI_PD           4
`define PCC_SI_EN           5
`define PCC_SI_CCLK         9
`define PCC_SI_CBRST        10
`define PCC_SI_STB          11
`define PCC_SI_WE           12
`define PCC_SI_ADDR         13
`define PCC_SI_WDATA        18
`define PCC_SI_DYN          26

`endif

// >>> hw/pcc_pkg.sv
`include "pcc_cfg.svh"

package pcc_pkg;

	typedef enum logic [2:0] {
		PCC_BUS_IDLE = 3'b001,
		PCC_BUS_ACK  = 3'b010,
		PCC_BUS_DONE = 3'b100
	} pcc_bus_st_t;

	typedef struct packed {
		logic [`PCC_SYNC_W-1:0] ff1;
		logic [`PCC_SYNC_W-1:0] ff2;
		logic [`PCC_SYNC_W-1:0] ff3;
		logic [`PCC_SYNC_W-1:0] val;
	} pcc_sync_t;

	typedef struct packed {
		pcc_bus_st_t                       bus_st;
		logic [`PCC_NUM_SET-1:0][7:0]      settings;
		logic                              ctrl_psrc;
		logic                              cclk_q;
		logic                              ack;
		logic [7:0]                        cfg_rdata;
		logic [31:0]                       prdata;
		logic                              lock;
		logic [`PCC_LOCK_CNT_W-1:0]        lock_cnt;
		logic [7:0]                        fb_cnt;
		logic [`PCC_NUM_OUT-1:0][7:0]      div_cnt;
		logic [`PCC_NUM_OUT-1:0]           out_clk;
	} pcc_state_t;

endpackage

// >>> hw/pcc_sync.sv
`timescale 1ns/1ps
`include "pcc_cfg.svh"

module pcc_sync (
	input  wire logic                    pclk,     // system clock
	input  wire logic                    presetn,  // async reset, active low
	input  wire logic [`PCC_SYNC_W-1:0]  din,      // raw pin levels
	output logic      [`PCC_SYNC_W-1:0]  dout      // filtered levels
);
	import pcc_pkg::*;

	pcc_sync_t st_ff;
	pcc_sync_t nxt_st;
	logic [`PCC_SYNC_W-1:0] agree;

	// ---------------------------------------------------------------
	// three stages, update once stages two and three agree
	// ---------------------------------------------------------------
	always_comb begin
		agree      = ~(st_ff.ff2 ^ st_ff.ff3);
		nxt_st     = st_ff;
		nxt_st.ff1 = din;
		nxt_st.ff2 = st_ff.ff1;
		nxt_st.ff3 = st_ff.ff2;
		nxt_st.val = (st_ff.ff3 & agree) | (st_ff.val & ~agree);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign dout = st_ff.val;

endmodule

// >>> hw/pcc_top.sv
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "pcc_cfg.svh"

// Contract
// (R1) One primary and three secondary output clocks are made, each with its own phase shift.
// (R2) The lock output is high while the loop is locked and is asynchronous to consumers.
// (R3) The phase source output shows whether phase comes from the input ports or the bus.
// (R4) The standby input powers the loop down.
// (R5) The basic loop reset resets the loop but leaves the feedback divider untouched.
// (R6) The full loop reset resets the loop and the feedback divider.
// (R7) The second secondary divider reset clears only that output's divider.
// (R8) The third secondary divider reset clears only that output's divider.
// (R9) Each output clock has its own enable and stays low while disabled.
// (R10) The configuration bus runs on its own bus clock, apart from the loop.
// (R11) The bus reset idles only the bus interface and keeps all stored settings.
// (R12) The master gives a five-bit address with the strobe to pick a setting.
// (R13) Write data comes in on an eight-bit bus and read data leaves on another.
// (R14) The master starts a transfer with the strobe, write enable high to write.
// (R15) The device answers each strobed transfer with acknowledge, read data valid with it.
// (R16) The master holds its request stable until acknowledge, then drops the strobe.
// (R17) After any loop reset or standby, lock stays low until the loop locks again.
module pcc_top (
	input  wire logic        pclk,                 // system clock, 100 MHz
	input  wire logic        presetn,              // async reset, active low
	input  wire logic [11:0] paddr,                // apb address
	input  wire logic        psel,                 // apb select
	input  wire logic        penable,              // apb enable
	input  wire logic        pwrite,               // apb direction
	input  wire logic [31:0] pwdata,               // apb write data
	output logic      [31:0] prdata,               // apb read data
	output logic             pready,               // apb ready
	output logic             pslverr,              // apb error
	input  wire logic        loop_reset,           // basic loop reset, high
	input  wire logic        full_loop_reset,      // loop and feedback reset, high
	input  wire logic        out_b_div_reset,      // output b divider reset, high
	input  wire logic        out_c_div_reset,      // output c divider reset, high
	input  wire logic        power_down_req,       // standby, high
	input  wire logic        primary_out_en,       // primary output enable
	input  wire logic        secondary_a_out_en,   // output a enable
	input  wire logic        secondary_b_out_en,   // output b enable
	input  wire logic        secondary_c_out_en,   // output c enable
	input  wire logic [31:0] dyn_phase_port,       // port phase, one byte per output
	input  wire logic        cfg_bus_clk,          // configuration bus clock
	input  wire logic        cfg_bus_reset,        // configuration bus reset, high
	input  wire logic        cfg_bus_strobe,       // transfer strobe
	input  wire logic        cfg_bus_write_en,     // high write, low read
	input  wire logic [4:0]  cfg_bus_addr,         // setting address
	input  wire logic [7:0]  cfg_bus_wdata,        // write data
	output logic      [7:0]  cfg_bus_rdata,        // read data
	output logic             cfg_bus_ack,          // transfer acknowledge
	output logic             primary_out_clk,      // primary output clock
	output logic             secondary_out_clk_a,  // secondary output a
	output logic             secondary_out_clk_b,  // secondary output b
	output logic             secondary_out_clk_c,  // secondary output c
	output logic             lock,                 // loop locked
	output logic             phase_source_sel_ind  // high: phase from bus
);
	import pcc_pkg::*;

	pcc_state_t st_ff;
	pcc_state_t nxt_st;

	// ---------------------------------------------------------------
	// pin synchronisation
	// ---------------------------------------------------------------
	logic [`PCC_SYNC_W-1:0] sync_in;
	logic [`PCC_SYNC_W-1:0] sync_out;

	assign sync_in = {dyn_phase_port, cfg_bus_wdata, cfg_bus_addr, cfg_bus_write_en,
	                  cfg_bus_strobe, cfg_bus_reset, cfg_bus_clk, secondary_c_out_en,
	                  secondary_b_out_en, secondary_a_out_en, primary_out_en,
	                  power_down_req, out_c_div_reset, out_b_div_reset,
	                  full_loop_reset, loop_reset};

	pcc_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (sync_in),
		.dout    (sync_out)
	);

	logic                    s_lrst;
	logic                    s_frst;
	logic                    s_pd;
	logic [`PCC_NUM_OUT-1:0] s_en;
	logic [`PCC_NUM_OUT-1:0] s_drst;
	logic                    s_cclk;
	logic                    s_cbrst;
	logic                    s_stb;
	logic                    s_we;
	logic [4:0]              s_addr;
	logic [7:0]              s_wdata;
	logic [31:0]             s_dyn;

	assign s_lrst  = sync_out[`PCC_SI_LRST];
	assign s_frst  = sync_out[`PCC_SI_FRST];
	assign s_pd    = sync_out[`PCC_SI_PD];
	assign s_en    = sync_out[`PCC_SI_EN +: `PCC_NUM_OUT];
	assign s_drst  = {sync_out[`PCC_SI_CRST], sync_out[`PCC_SI_BRST], 2'b00};
	assign s_cclk  = sync_out[`PCC_SI_CCLK];
	assign s_cbrst = sync_out[`PCC_SI_CBRST];
	assign s_stb   = sync_out[`PCC_SI_STB];
	assign s_we    = sync_out[`PCC_SI_WE];
	assign s_addr  = sync_out[`PCC_SI_ADDR +: 5];
	assign s_wdata = sync_out[`PCC_SI_WDATA +: 8];
	assign s_dyn   = sync_out[`PCC_SI_DYN +: 32];

	// ---------------------------------------------------------------
	// loop run condition
	// ---------------------------------------------------------------
	logic running;
	logic cfg_rise;

	assign running  = ~s_pd & ~s_lrst & ~s_frst;
	assign cfg_rise = s_cclk & ~st_ff.cclk_q;

	// ---------------------------------------------------------------
	// per-output divider with phase offset
	// ---------------------------------------------------------------
	logic [`PCC_NUM_OUT-1:0][7:0] div_nxt;
	logic [`PCC_NUM_OUT-1:0]      div_hi;
	logic [`PCC_NUM_OUT-1:0]      div_clr;

	for (genvar g = 0; g < `PCC_NUM_OUT; g++) begin : g_div
		logic [7:0] raw_n;
		logic [7:0] n;
		logic [7:0] ph;
		logic [8:0] sum;
		logic [8:0] pos;

		assign raw_n = st_ff.settings[`PCC_DIV_BASE + g];
		assign n     = (raw_n < `PCC_DIV_MIN) ? `PCC_DIV_MIN : raw_n;
		// phase taken from the bus setting or the port byte
		assign ph    = st_ff.ctrl_psrc ? st_ff.settings[`PCC_PH_BASE + g]
		                               : s_dyn[g*8 +: 8];  // [R3]
		assign sum   = {1'b0, st_ff.div_cnt[g]} + {1'b0, ph};
		assign pos   = (sum >= {1'b0, n}) ? (sum - {1'b0, n}) : sum;
		assign div_hi[g]  = pos < {2'b00, n[7:1]};  // [R1]
		assign div_nxt[g] = (st_ff.div_cnt[g] >= (n - 8'h01)) ? 8'h00
		                                                      : (st_ff.div_cnt[g] + 8'h01);
		assign div_clr[g] = ~running | s_drst[g];  // [R7] [R8]
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	logic        apb_acc;
	logic        apb_setup;
	logic        addr_ok;
	logic [31:0] status_word;
	logic [7:0]  fb_n;

	assign apb_acc   = psel & penable;
	assign apb_setup = psel & ~penable;
	assign addr_ok   = (paddr == `PCC_CTRL_OFS) | (paddr == `PCC_STATUS_OFS);
	assign fb_n      = (st_ff.settings[`PCC_FB_ADDR] < `PCC_DIV_MIN) ? `PCC_DIV_MIN
	                                                                : st_ff.settings[`PCC_FB_ADDR];

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`PCC_ST_LOCK_BIT] = st_ff.lock;
		status_word[`PCC_ST_PSRC_BIT] = st_ff.ctrl_psrc;
		status_word[`PCC_ST_PD_BIT]   = s_pd;
		status_word[`PCC_ST_RST_BIT]  = s_lrst | s_frst;
		status_word[`PCC_ST_FB_LSB +: 8] = st_ff.fb_cnt;
	end

	always_comb begin
		nxt_st        = st_ff;
		nxt_st.cclk_q = s_cclk;

		// apb read data captured in the setup cycle
		if (apb_setup) begin
			if (paddr == `PCC_CTRL_OFS) begin
				nxt_st.prdata = {31'h0000_0000, st_ff.ctrl_psrc};
			end else if (paddr == `PCC_STATUS_OFS) begin
				nxt_st.prdata = status_word;
			end else begin
				nxt_st.prdata = 32'h0000_0000;
			end
		end
		if (apb_acc && pwrite && (paddr == `PCC_CTRL_OFS)) begin
			nxt_st.ctrl_psrc = pwdata[`PCC_CTRL_PSRC_BIT];  // [R3]
		end

		// feedback divider: only the full reset clears it
		if (s_frst) begin
			nxt_st.fb_cnt = 8'h00;  // [R6]
		end else if (running) begin
			nxt_st.fb_cnt = (st_ff.fb_cnt >= (fb_n - 8'h01)) ? 8'h00
			                                                  : (st_ff.fb_cnt + 8'h01);
		end else begin
			nxt_st.fb_cnt = st_ff.fb_cnt;  // [R5]
		end

		// lock acquisition
		if (!running) begin
			nxt_st.lock     = 1'b0;  // [R4] [R5] [R17]
			nxt_st.lock_cnt = '0;
		end else if (!st_ff.lock) begin
			nxt_st.lock_cnt = st_ff.lock_cnt + `PCC_LOCK_CNT_W'(1);
			if (st_ff.lock_cnt == `PCC_LOCK_CNT_W'(`PCC_LOCK_CYCLES - 1)) begin
				nxt_st.lock = 1'b1;  // [R2] [R17]
			end
		end

		// output dividers and gates
		for (int i = 0; i < `PCC_NUM_OUT; i++) begin
			if (div_clr[i]) begin
				nxt_st.div_cnt[i] = 8'h00;  // [R4] [R7] [R8]
				nxt_st.out_clk[i] = 1'b0;
			end else begin
				nxt_st.div_cnt[i] = div_nxt[i];
				nxt_st.out_clk[i] = s_en[i] & div_hi[i];  // [R9]
			end
		end

		// configuration bus, stepped on its own clock edges
		if (s_cbrst) begin
			nxt_st.bus_st = PCC_BUS_IDLE;  // [R11]
			nxt_st.ack    = 1'b0;
		end else if (cfg_rise) begin  // [R10]
			unique case (st_ff.bus_st)
				PCC_BUS_IDLE: begin
					if (s_stb) begin  // [R12] [R14]
						if (s_we) begin
							nxt_st.settings[s_addr] = s_wdata;  // [R13]
						end else begin
							nxt_st.cfg_rdata = st_ff.settings[s_addr];  // [R13]
						end
						nxt_st.ack    = 1'b1;  // [R15]
						nxt_st.bus_st = PCC_BUS_ACK;
					end
				end
				PCC_BUS_ACK: begin
					nxt_st.ack    = 1'b0;
					nxt_st.bus_st = PCC_BUS_DONE;
				end
				PCC_BUS_DONE: begin
					if (!s_stb) begin  // [R16]
						nxt_st.bus_st = PCC_BUS_IDLE;
					end
				end
				default: begin
					nxt_st.bus_st = PCC_BUS_IDLE;
					nxt_st.ack    = 1'b0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff           <= '0;
			st_ff.bus_st    <= PCC_BUS_IDLE;
			st_ff.ctrl_psrc <= `PCC_CTRL_RST;
			for (int k = 0; k < `PCC_NUM_SET; k++) begin
				st_ff.settings[k] <= `PCC_SET_RST;
			end
			for (int k = 0; k < `PCC_NUM_OUT; k++) begin
				st_ff.settings[`PCC_DIV_BASE + k] <= `PCC_DIV_RST;
			end
			st_ff.settings[`PCC_FB_ADDR] <= `PCC_FB_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign prdata               = st_ff.prdata;
	assign pready               = 1'b1;
	assign pslverr              = apb_acc & ~addr_ok;
	assign cfg_bus_rdata        = st_ff.cfg_rdata;
	assign cfg_bus_ack          = st_ff.ack;
	assign primary_out_clk      = st_ff.out_clk[0];
	assign secondary_out_clk_a  = st_ff.out_clk[1];
	assign secondary_out_clk_b  = st_ff.out_clk[2];
	assign secondary_out_clk_c  = st_ff.out_clk[3];
	assign lock                 = st_ff.lock;
	assign phase_source_sel_ind = st_ff.ctrl_psrc;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	lock_drop_a: assert property (!running |=> !lock)  // [R17]
		else $error("lock high while loop not running");
	lock_hold_a: assert property (lock && running |=> lock)  // [R2]
		else $error("lock lost while loop running");
	out_gate_a: assert property (1'b1 |=> ((st_ff.out_clk & ~$past(s_en)) == 4'h0))  // [R9]
		else $error("output clock toggles while disabled");
	fb_keep_a: assert property (s_lrst && !s_frst |=> st_ff.fb_cnt == $past(st_ff.fb_cnt))  // [R5]
		else $error("basic reset disturbed feedback divider");
	fb_clear_a: assert property (s_frst |=> (st_ff.fb_cnt == 8'h00) && !lock)  // [R6]
		else $error("full reset left feedback divider or lock");
	div_b_rst_a: assert property (s_drst[2] |=> (st_ff.div_cnt[2] == 8'h00) && !secondary_out_clk_b)  // [R7]
		else $error("output b divider not held in reset");
	div_c_rst_a: assert property (s_drst[3] |=> (st_ff.div_cnt[3] == 8'h00) && !secondary_out_clk_c)  // [R8]
		else $error("output c divider not held in reset");
	div_a_free_a: assert property (running && !s_drst[1] && (st_ff.div_cnt[1] == 8'h00)
		|=> st_ff.div_cnt[1] == 8'h01)  // [R7]
		else $error("output a divider disturbed");
	standby_a: assert property (s_pd |=> (st_ff.out_clk == 4'h0) && !lock)  // [R4]
		else $error("standby did not power down loop");
	rd_data_a: assert property ($rose(cfg_bus_ack) && !$past(s_we)
		|-> cfg_bus_rdata == st_ff.settings[$past(s_addr)])  // [R15]
		else $error("read data not valid with acknowledge");
	bus_rst_a: assert property (s_cbrst |=> !cfg_bus_ack && (st_ff.settings == $past(st_ff.settings)))  // [R11]
		else $error("bus reset disturbed settings or ack");
	psrc_wr_a: assert property (apb_acc && pwrite && (paddr == `PCC_CTRL_OFS)
		|=> phase_source_sel_ind == $past(pwdata[0]))  // [R3]
		else $error("phase source indicator not updated");

endmodule

// >>> hw/pcc_placeholder_none.sv
`timescale 1ns/1ps

// >>> bench/pcc_cfg_master.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// fabric master of the configuration bus
// ---------------------------------------------------------------
module pcc_cfg_master (
	input  wire logic       pclk,              // system clock
	output logic            cfg_bus_clk,       // bus clock, still between frames
	output logic            cfg_bus_strobe,    // transfer strobe
	output logic            cfg_bus_write_en,  // high write, low read
	output logic [4:0]      cfg_bus_addr,      // setting address
	output logic [7:0]      cfg_bus_wdata,     // write data
	input  wire logic [7:0] cfg_bus_rdata,     // read data
	input  wire logic       cfg_bus_ack        // acknowledge
);
	localparam int HALF = 10;

	initial begin
		cfg_bus_clk = 1'b0;
		cfg_bus_strobe = 1'b0;
		cfg_bus_write_en = 1'b0;
		cfg_bus_addr = 5'h00;
		cfg_bus_wdata = 8'h00;
	end

	task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ok);
		int n;
		ok = 1'b0;
		q = 8'h00;
		@(posedge pclk);
		cfg_bus_strobe <= 1'b1;
		cfg_bus_write_en <= w;
		cfg_bus_addr <= a;
		cfg_bus_wdata <= d;
		for (n = 0; n < 8 && !ok; n++) begin
			repeat (HALF) @(posedge pclk);
			ok = (cfg_bus_ack === 1'b1);
			if (ok)
				q = cfg_bus_rdata;
			cfg_bus_clk <= 1'b1;
			repeat (HALF) @(posedge pclk);
			cfg_bus_clk <= 1'b0;
		end
		// released lines show the inverse, strobe low for one more edge
		cfg_bus_strobe <= 1'b0;
		cfg_bus_write_en <= ~w;
		cfg_bus_addr <= ~a;
		cfg_bus_wdata <= ~d;
		repeat (HALF) @(posedge pclk);
		cfg_bus_clk <= 1'b1;
		repeat (HALF) @(posedge pclk);
		cfg_bus_clk <= 1'b0;
	endtask
endmodule

// >>> bench/pcc_top_tb.sv
`timescale 1ns/1ps
`include "pcc_cfg.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin mismatches++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end

module pcc_top_tb;
	import pcc_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  src = 3'h0;
	logic [3:0]  en = 4'h0;
	logic [1:0]  drst = 2'h0;
	logic        cfg_bus_reset = 1'b0;
	logic [31:0] dyn = 32'h0000_0000;
	logic        cclk;
	logic        stb;
	logic        we;
	logic [4:0]  caddr;
	logic [7:0]  cwdata;
	logic [7:0]  crdata;
	logic        cack;
	wire  [3:0]  oclk;
	logic        lock;
	logic        psi;
	logic [31:0] q;
	logic [31:0] q2;
	logic [7:0]  b;
	logic        e;
	int          mismatches = 0;
	int          comparisons = 0;
	int          cyc = 0;

	always #5 pclk = ~pclk;

	pcc_top u_pcc_top (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.loop_reset(src[0]), .full_loop_reset(src[1]), .out_b_div_reset(drst[0]),
		.out_c_div_reset(drst[1]), .power_down_req(src[2]), .primary_out_en(en[0]),
		.secondary_a_out_en(en[1]), .secondary_b_out_en(en[2]), .secondary_c_out_en(en[3]),
		.dyn_phase_port(dyn), .cfg_bus_clk(cclk), .cfg_bus_reset(cfg_bus_reset),
		.cfg_bus_strobe(stb), .cfg_bus_write_en(we), .cfg_bus_addr(caddr),
		.cfg_bus_wdata(cwdata), .cfg_bus_rdata(crdata), .cfg_bus_ack(cack),
		.primary_out_clk(oclk[0]), .secondary_out_clk_a(oclk[1]), .secondary_out_clk_b(oclk[2]),
		.secondary_out_clk_c(oclk[3]), .lock(lock), .phase_source_sel_ind(psi)
	);

	pcc_cfg_master u_pcc_cfg_master (
		.pclk(pclk), .cfg_bus_clk(cclk), .cfg_bus_strobe(stb), .cfg_bus_write_en(we),
		.cfg_bus_addr(caddr), .cfg_bus_wdata(cwdata), .cfg_bus_rdata(crdata),
		.cfg_bus_ack(cack)
	);

	// ---------------------------------------------------------------
	// bus tasks
	// ---------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cfg(input logic w, input logic [4:0] a, input logic [7:0] d);
		logic ok;
		u_pcc_cfg_master.xfer(w, a, d, b, ok);
		`CHK("cfg ack", 1'b1, ok)
	endtask

	task automatic wait_lock();
		int n;
		n = 0;
		while (lock !== 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		`CHK("lock acquired", 1'b1, lock)
	endtask

	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		apb(1'b0, `PCC_CTRL_OFS, 32'h0);
		`CHK("ctrl reset", 32'h0000_0000, q)
		apb(1'b1, `PCC_CTRL_OFS, 32'h0000_0001);
		apb(1'b0, `PCC_CTRL_OFS, 32'h0);
		`CHK("ctrl set", 32'h0000_0001, q)
		`CHK("phase source", 1'b1, psi)
		apb(1'b1, `PCC_STATUS_OFS, 32'hffff_ffff);
		`CHK("status write err", 1'b0, e)
		apb(1'b0, `PCC_STATUS_OFS, 32'h0);
		`CHK("status psrc", 1'b1, q[`PCC_ST_PSRC_BIT])
		apb(1'b0, 12'h010, 32'h0);
		`CHK("unmapped err", 1'b1, e)
		`CHK("unmapped data", 32'h0000_0000, q)
		apb(1'b1, `PCC_CTRL_OFS, 32'h0);
		@(posedge pclk);
		`CHK("phase source off", 1'b0, psi)
	endtask

	task automatic t_cfg();
		cfg(1'b0, `PCC_DIV_BASE, 8'h00);
		`CHK("div reset", 8'h02, b)
		cfg(1'b0, `PCC_FB_ADDR, 8'h00);
		`CHK("fb reset", 8'h04, b)
		cfg(1'b1, 5'h09, 8'ha5);
		cfg(1'b1, 5'h1f, 8'h3c);
		cfg(1'b0, 5'h09, 8'h00);
		`CHK("set 9", 8'ha5, b)
		cfg(1'b0, 5'h1f, 8'h00);
		`CHK("set 31", 8'h3c, b)
		cfg_bus_reset <= 1'b1;
		repeat (20) @(posedge pclk);
		cfg_bus_reset <= 1'b0;
		repeat (8) @(posedge pclk);
		`CHK("ack idle", 1'b0, cack)
		cfg(1'b0, 5'h09, 8'h00);
		`CHK("kept 9", 8'ha5, b)
	endtask

	task automatic t_lock();
		int k;
		wait_lock();
		for (k = 0; k < 3; k++) begin
			src <= 3'h1 << k;
			repeat (12) @(posedge pclk);
			`CHK("lock dropped", 1'b0, lock)
			`CHK("outputs stopped", 4'h0, oclk)
			apb(1'b0, `PCC_STATUS_OFS, 32'h0);
			q2 = q;
			`CHK("status cause", 1'b1, q[k == 2 ? `PCC_ST_PD_BIT : `PCC_ST_RST_BIT])
			apb(1'b0, `PCC_STATUS_OFS, 32'h0);
			if (k == 1)
				`CHK("fb cleared", 8'h00, q[15:8])
			if (k == 0)
				`CHK("fb held", q2[15:8], q[15:8])
			src <= 3'h0;
			repeat (60) @(posedge pclk);
			`CHK("lock early", 1'b0, lock)
			wait_lock();
		end
	endtask

	task automatic t_outs();
		int i;
		int j;
		int n;
		int r[4];
		logic [3:0] pv;
		logic [5:0] tbl[6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h1f, 6'h2f};
		cfg(1'b1, `PCC_DIV_BASE, 8'h04);
		for (i = 0; i < 6; i++) begin
			en <= tbl[i][3:0];
			drst <= tbl[i][5:4];
			repeat (12) @(posedge pclk);
			r = '{0, 0, 0, 0};
			pv = oclk;
			for (n = 0; n < 40; n++) begin
				@(posedge pclk);
				for (j = 0; j < 4; j++)
					r[j] += (oclk[j] && !pv[j]);
				pv = oclk;
			end
			for (j = 0; j < 4; j++)
				`CHK("rises", (tbl[i][j] && !(j > 1 && tbl[i][j + 2])) ? 40 / (j == 0 ? 4 : 2) : 0,
					r[j])
		end
		drst <= 2'h0;
	endtask

	// output a against the primary output: port phase, then bus phase
	task automatic t_phase();
		int p;
		logic pv;
		en <= 4'hf;
		for (p = 0; p < 3; p++) begin
			dyn <= (p == 0) ? 32'h0000_0000 : 32'h0000_0100;
			if (p == 2)
				apb(1'b1, `PCC_CTRL_OFS, 32'h0000_0001);
			repeat (12) @(posedge pclk);
			pv = 1'b1;
			while (!(oclk[0] && !pv)) begin
				pv = oclk[0];
				@(posedge pclk);
			end
			`CHK("phase shift", (p != 1), oclk[1])
		end
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			report_and_stop();
		end
	end

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_cfg();
		t_lock();
		t_outs();
		t_phase();
		report_and_stop();
	end
endmodule
